// File: include/pte_params.svh
`ifndef PTE_PARAMS_SVH
`define PTE_PARAMS_SVH
// bus shape
`define PTE_ADDR_W 5
`define PTE_DATA_W 16
`define PTE_DATA_ZERO 16'h0000
// register offsets
`define PTE_OFS_LINE_TEST 5'h1B
`define PTE_OFS_EXTRA_CTRL 5'h1C
`define PTE_OFS_WAKE 5'h1D
// line_test_and_selftest_ext fields
`define PTE_TALLY_HI 15
`define PTE_TALLY_LO 8
`define PTE_CTRL_HI 7
`define PTE_NONSTOP_BIT 5
`define PTE_PATT_EN_BIT 4
`define PTE_GAP_SEL_BIT 2
`define PTE_PSEL_HI 1
`define PTE_PSEL_LO 0
`define PTE_CTRL_RST 8'h00
`define PTE_TALLY_RST 8'h00
`define PTE_TALLY_MAX 8'hFF
`define PTE_TALLY_ONE 8'h01
// extra_phy_control fields
`define PTE_SOFT_RST_BIT 9
// wake_sense_control fields
`define PTE_WS_EN_BIT 15
`define PTE_WS_UP_BIT 14
`define PTE_WS_DOWN_BIT 13
`define PTE_WS_MAN_BIT 12
`define PTE_WS_BURST_BIT 11
`define PTE_WS_PWR_BIT 10
`define PTE_WS_ERRMET_BIT 9
`define PTE_WS_DATAMET_BIT 8
`define PTE_WS_ERRTH_HI 7
`define PTE_WS_ERRTH_LO 4
`define PTE_WS_DATTH_HI 3
`define PTE_WS_DATTH_LO 0
`define PTE_WS_AUTO_RST 1'b1
`define PTE_TH_RST 4'h1
`define PTE_CNT_W 4
`define PTE_CNT_MAX 4'hF
`define PTE_CNT_ZERO 4'h0
`define PTE_CNT_ONE 4'h1
// timing
`define PTE_CLK_HZ 100000000
`define PTE_CLK_NS 10
`define PTE_GAP_LONG_NS 15000
`define PTE_GAP_SHORT_NS 10000
`define PTE_GAP_LONG_CYC (`PTE_GAP_LONG_NS / `PTE_CLK_NS)
`define PTE_GAP_SHORT_CYC (`PTE_GAP_SHORT_NS / `PTE_CLK_NS)
`define PTE_GAP_W 11
`define PTE_GAP_ZERO 11'h000
`define PTE_GAP_ONE 11'h001
`define PTE_QUIET_S 2
`define PTE_QUIET_CYC (`PTE_QUIET_S * `PTE_CLK_HZ)
`define PTE_QUIET_W 28
`define PTE_QUIET_ZERO 28'h0000000
`define PTE_QUIET_ONE 28'h0000001
// pin synchroniser
`define PTE_SYNC_N 3
`endif

// File: include/pte_pkg.sv
package pte_pkg;
	// energy detect power state
	typedef enum logic {
		ST_DOWN,
		ST_UP
	} pte_wake_state_e;
	// one received nibble from the self-test checker
	typedef struct packed {
		logic valid;
		logic error;
	} pte_nibble_s;
	// line driver test pattern controls
	typedef struct packed {
		logic enable;
		logic gap_long;
		logic [1:0] sel;
	} pte_patt_s;
	// line energy events from the receive front end
	typedef struct packed {
		logic data_evt;
		logic err_evt;
		logic energy;
	} pte_sense_s;
endpackage : pte_pkg

// File: logic/pte_wake_fsm.sv
`include "pte_params.svh"
module pte_wake_fsm #(
	parameter int unsigned QUIET_CYC = `PTE_QUIET_CYC
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_any, // srst or soft reset
	input wire logic enable, // energy detect allowed
	input wire logic auto_up, // automatic power up
	input wire logic auto_down, // automatic power down
	input wire logic manual, // one-cycle forced toggle
	input wire logic [3:0] data_th, // data event threshold
	input wire logic [3:0] err_th, // error event threshold
	input wire pte_pkg::pte_sense_s sense, // line events
	output logic power_up, // current power state
	output logic up_start, // power-up sequence start
	output logic down_start, // power-down sequence start
	output logic data_met, // data threshold reached pulse
	output logic err_met // error threshold reached pulse
);
	pte_pkg::pte_wake_state_e state_reg, state_next;
	logic [3:0] data_cnt_reg, data_cnt_next;
	logic [3:0] err_cnt_reg, err_cnt_next;
	logic [`PTE_QUIET_W-1:0] quiet_reg, quiet_next;
	wire quiet_done = (quiet_reg == `PTE_QUIET_W'(QUIET_CYC - 1));
	wire [3:0] data_inc = (data_cnt_reg == `PTE_CNT_MAX) ?
		data_cnt_reg : data_cnt_reg + `PTE_CNT_ONE;
	wire [3:0] err_inc = (err_cnt_reg == `PTE_CNT_MAX) ?
		err_cnt_reg : err_cnt_reg + `PTE_CNT_ONE;
	wire [3:0] data_now = sense.data_evt ? data_inc : data_cnt_reg;
	wire [3:0] err_now = sense.err_evt ? err_inc : err_cnt_reg;
	wire data_hit = enable & (data_now >= data_th);
	wire err_hit = enable & (err_now >= err_th);
	// state changes: manual wins over thresholds and timers
	wire go_up = enable & (state_reg == pte_pkg::ST_DOWN) &
		(manual | (auto_up & data_hit));
	wire go_down = enable & (state_reg == pte_pkg::ST_UP) &
		(manual | (auto_down & ~sense.energy));
	assign up_start = go_up;
	assign down_start = go_down;
	assign data_met = data_hit & sense.data_evt;
	assign err_met = err_hit & sense.err_evt;
	assign power_up = (state_reg == pte_pkg::ST_UP);

	// next state and event counters
	always_comb begin
		state_next = state_reg;
		if (go_up) begin
			state_next = pte_pkg::ST_UP;
		end else if (go_down) begin
			state_next = pte_pkg::ST_DOWN;
		end
		data_cnt_next = data_now;
		err_cnt_next = err_now;
		quiet_next = quiet_reg + `PTE_QUIET_ONE;
		case (state_next)
			pte_pkg::ST_UP: begin
				if (go_up) begin
					data_cnt_next = `PTE_CNT_ZERO;
					err_cnt_next = `PTE_CNT_ZERO;
				end
			end
			pte_pkg::ST_DOWN: begin
				if (go_down) begin
					data_cnt_next = `PTE_CNT_ZERO;
					err_cnt_next = `PTE_CNT_ZERO;
				end
			end
			default: begin
				state_next = pte_pkg::ST_DOWN;
			end
		endcase
		if (sense.data_evt) begin
			quiet_next = `PTE_QUIET_ZERO;
		end else if (quiet_done) begin
			quiet_next = `PTE_QUIET_ZERO;
			data_cnt_next = `PTE_CNT_ZERO;
			err_cnt_next = `PTE_CNT_ZERO;
		end
	end

	// state registers
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			state_reg <= pte_pkg::ST_UP;
			data_cnt_reg <= `PTE_CNT_ZERO;
			err_cnt_reg <= `PTE_CNT_ZERO;
			quiet_reg <= `PTE_QUIET_ZERO;
		end else begin
			state_reg <= state_next;
			data_cnt_reg <= data_cnt_next;
			err_cnt_reg <= err_cnt_next;
			quiet_reg <= quiet_next;
		end
	end
endmodule : pte_wake_fsm

// File: logic/pte_regs.sv
// What this block does
// - count errored self-test nibbles in upper byte
// - clear error tally on each self-test restart
// - error tally saturates at maximum, never wraps
// - nonstop bit gives unbroken pseudo-random self-test
// - enable bit starts the 10M pattern generator
// - gap select: 15 us set, 10 us clear
// - select picks data/marker0, data/marker1, pulses, tone
// - soft reset clears logic, keeps registers, self-clears
// - other extra control bits ignore writes, read zero
// - wake enable resets from strap, software writable
// - auto wake powers up at data threshold
// - auto sleep powers down without line energy
// - manual bit forces power change, self-clears
// - event counters reset after two quiet seconds
// - jabber guard bit disables jabber, 10M only
//
// The strobed register port is this design's own decision.
`include "pte_params.svh"
module pte_regs #(
	parameter int unsigned QUIET_CYC = `PTE_QUIET_CYC
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic srst, // synchronous reset, high
	input wire logic [`PTE_ADDR_W-1:0] reg_addr, // register address
	input wire logic [`PTE_DATA_W-1:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [`PTE_DATA_W-1:0] reg_rdata, // read data, next cycle
	input wire logic selftest_run, // main self-test running
	input wire pte_pkg::pte_nibble_s rx_nibble, // checked nibble
	output logic selftest_nonstop_mode, // nonstop self-test active
	output pte_pkg::pte_patt_s patt_ctrl, // pattern generator setup
	output logic patt_seq_start, // start one test sequence
	input wire logic patt_seq_done, // test sequence finished
	input wire logic jabber_guard_off, // jabber disable control
	input wire logic link_is_10m, // link runs 10BASE-T
	output logic jabber_active, // jabber function in force
	input wire logic wake_sense_strap, // strap pin for enable
	input wire pte_pkg::pte_sense_s line_sense, // energy events
	output logic wake_power_up, // energy detect powered up
	output logic wake_up_start, // power-up sequence pulse
	output logic wake_down_start, // power-down sequence pulse
	output logic device_soft_reset // soft reset pulse to core
);
	// address decode helper
	function automatic logic addr_hit(
		input logic [`PTE_ADDR_W-1:0] a,
		input logic [`PTE_ADDR_W-1:0] ofs
	);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] tally_reg, tally_next;
	logic run_d_reg;
	logic soft_rst_reg;
	logic nonstop_reg;
	logic ws_en_reg, ws_en_next;
	logic ws_up_reg, ws_down_reg, ws_burst_reg;
	logic ws_man_reg;
	logic [3:0] ws_errth_reg, ws_datth_reg;
	logic ws_errmet_reg, ws_errmet_next;
	logic ws_datmet_reg, ws_datmet_next;
	logic strap_taken_reg;
	logic [`PTE_SYNC_N-1:0] strap_sync_reg;
	logic [`PTE_DATA_W-1:0] rdata_reg, rdata_next;
	logic seq_busy_reg, seq_busy_next;
	logic [`PTE_GAP_W-1:0] gap_reg, gap_next;
	logic rst_core;
	logic data_met_evt, err_met_evt;

	// register select strobes
	wire wr_line = reg_wr & addr_hit(reg_addr, `PTE_OFS_LINE_TEST);
	wire wr_extra = reg_wr & addr_hit(reg_addr, `PTE_OFS_EXTRA_CTRL);
	wire wr_wake = reg_wr & addr_hit(reg_addr, `PTE_OFS_WAKE);
	wire rd_line = reg_rd & addr_hit(reg_addr, `PTE_OFS_LINE_TEST);
	wire rd_extra = reg_rd & addr_hit(reg_addr, `PTE_OFS_EXTRA_CTRL);
	wire rd_wake = reg_rd & addr_hit(reg_addr, `PTE_OFS_WAKE);

	// core logic reset: hard reset or software soft reset
	// one-cycle pulse, so the bus is usable right after
	assign rst_core = srst | soft_rst_reg;
	assign device_soft_reset = soft_rst_reg;

	// strap pin synchroniser, stage 0 feeds stage 1 only
	// stage 0 may go metastable, nothing else reads it
	always_ff @(posedge clk_sys) begin
		strap_sync_reg[0] <= wake_sense_strap;
	end
	genvar gi;
	generate
		for (gi = 1; gi < `PTE_SYNC_N; gi++) begin : g_sync
			always_ff @(posedge clk_sys) begin
				strap_sync_reg[gi] <= strap_sync_reg[gi-1];
			end
		end
	endgenerate
	wire strap_agree = (strap_sync_reg[1] == strap_sync_reg[2]);
	wire strap_level = strap_sync_reg[2];

	// test control byte: all low bits are plain read-write
	assign ctrl_next = wr_line ? reg_wdata[`PTE_CTRL_HI:0] : ctrl_reg;

	// self-test restart is the rising edge of the run level
	// a restart beside a bad nibble still clears the tally
	wire run_rise = selftest_run & ~run_d_reg;
	wire nib_bad = selftest_run & rx_nibble.valid & rx_nibble.error;
	wire tally_full = (tally_reg == `PTE_TALLY_MAX);
	assign tally_next = run_rise ? `PTE_TALLY_RST :
		(nib_bad & ~tally_full) ? tally_reg + `PTE_TALLY_ONE :
		tally_reg;

	// test control register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_reg <= `PTE_CTRL_RST;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// tally is device state, cleared by soft reset too
	always_ff @(posedge clk_sys) begin
		if (rst_core) begin
			tally_reg <= `PTE_TALLY_RST;
			run_d_reg <= 1'b0;
			nonstop_reg <= 1'b0;
		end else begin
			tally_reg <= tally_next;
			run_d_reg <= selftest_run;
			nonstop_reg <= ctrl_reg[`PTE_NONSTOP_BIT] & selftest_run;
		end
	end
	assign selftest_nonstop_mode = nonstop_reg;

	// pattern generator controls straight from the register
	assign patt_ctrl.enable = ctrl_reg[`PTE_PATT_EN_BIT];
	assign patt_ctrl.gap_long = ctrl_reg[`PTE_GAP_SEL_BIT];
	assign patt_ctrl.sel = ctrl_reg[`PTE_PSEL_HI:`PTE_PSEL_LO];

	// sequence spacing: gap counted from end of each sequence
	wire patt_en = ctrl_reg[`PTE_PATT_EN_BIT];
	wire [`PTE_GAP_W-1:0] gap_load = ctrl_reg[`PTE_GAP_SEL_BIT] ?
		`PTE_GAP_W'(`PTE_GAP_LONG_CYC) :
		`PTE_GAP_W'(`PTE_GAP_SHORT_CYC);
	wire gap_zero = (gap_reg == `PTE_GAP_ZERO);
	assign patt_seq_start = patt_en & ~seq_busy_reg & gap_zero;

	// sequencer next values
	// dropping the enable abandons a pending gap at once
	always_comb begin
		seq_busy_next = seq_busy_reg;
		gap_next = gap_reg;
		if (~patt_en) begin
			seq_busy_next = 1'b0;
			gap_next = `PTE_GAP_ZERO;
		end else if (patt_seq_start) begin
			seq_busy_next = 1'b1;
		end else if (seq_busy_reg & patt_seq_done) begin
			seq_busy_next = 1'b0;
			gap_next = gap_load;
		end else if (~gap_zero) begin
			gap_next = gap_reg - `PTE_GAP_ONE;
		end
	end

	// sequencer registers
	always_ff @(posedge clk_sys) begin
		if (rst_core) begin
			seq_busy_reg <= 1'b0;
			gap_reg <= `PTE_GAP_ZERO;
		end else begin
			seq_busy_reg <= seq_busy_next;
			gap_reg <= gap_next;
		end
	end

	// jabber only exists in 10BASE-T operation
	// guard input has no effect on a 100M link
	always_ff @(posedge clk_sys) begin
		if (rst_core) begin
			jabber_active <= 1'b0;
		end else begin
			jabber_active <= link_is_10m & ~jabber_guard_off;
		end
	end

	// soft reset bit: one-cycle pulse, then reads zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			soft_rst_reg <= 1'b0;
		end else begin
			soft_rst_reg <= wr_extra & reg_wdata[`PTE_SOFT_RST_BIT];
		end
	end

	// wake enable: strap caught once after reset, then software
	// a write before the strap settles wins over the strap
	always_comb begin
		ws_en_next = ws_en_reg;
		if (wr_wake) begin
			ws_en_next = reg_wdata[`PTE_WS_EN_BIT];
		end else if (~strap_taken_reg & strap_agree) begin
			ws_en_next = strap_level;
		end
	end

	// clear-on-read met flags, a new event beats the read
	assign ws_errmet_next = err_met_evt | (ws_errmet_reg & ~rd_wake);
	assign ws_datmet_next = data_met_evt | (ws_datmet_reg & ~rd_wake);

	// wake sense register fields, kept over soft reset
	// thresholds come up at one event each
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ws_en_reg <= 1'b0;
			strap_taken_reg <= 1'b0;
			ws_up_reg <= `PTE_WS_AUTO_RST;
			ws_down_reg <= `PTE_WS_AUTO_RST;
			ws_burst_reg <= 1'b0;
			ws_errth_reg <= `PTE_TH_RST;
			ws_datth_reg <= `PTE_TH_RST;
		end else begin
			ws_en_reg <= ws_en_next;
			strap_taken_reg <= strap_taken_reg | strap_agree | wr_wake;
			if (wr_wake) begin
				ws_up_reg <= reg_wdata[`PTE_WS_UP_BIT];
				ws_down_reg <= reg_wdata[`PTE_WS_DOWN_BIT];
				ws_burst_reg <= reg_wdata[`PTE_WS_BURST_BIT];
				ws_errth_reg <= reg_wdata[`PTE_WS_ERRTH_HI:`PTE_WS_ERRTH_LO];
				ws_datth_reg <= reg_wdata[`PTE_WS_DATTH_HI:`PTE_WS_DATTH_LO];
			end
		end
	end

	// manual toggle and met flags are live state
	always_ff @(posedge clk_sys) begin
		if (rst_core) begin
			ws_man_reg <= 1'b0;
			ws_errmet_reg <= 1'b0;
			ws_datmet_reg <= 1'b0;
		end else begin
			ws_man_reg <= wr_wake & reg_wdata[`PTE_WS_MAN_BIT];
			ws_errmet_reg <= ws_errmet_next;
			ws_datmet_reg <= ws_datmet_next;
		end
	end

	// energy detect power state machine
	// state and counters restart on soft reset
	pte_wake_fsm #(
		.QUIET_CYC(QUIET_CYC)
	) u_wake (
		.clk_sys(clk_sys),
		.rst_any(rst_core),
		.enable(ws_en_reg),
		.auto_up(ws_up_reg),
		.auto_down(ws_down_reg),
		.manual(ws_man_reg),
		.data_th(ws_datth_reg),
		.err_th(ws_errth_reg),
		.sense(line_sense),
		.power_up(wake_power_up),
		.up_start(wake_up_start),
		.down_start(wake_down_start),
		.data_met(data_met_evt),
		.err_met(err_met_evt)
	);

	// read data words per register
	wire [`PTE_DATA_W-1:0] line_word = {tally_reg, ctrl_reg};
	wire [`PTE_DATA_W-1:0] extra_word =
		`PTE_DATA_W'(soft_rst_reg) << `PTE_SOFT_RST_BIT;
	wire [`PTE_DATA_W-1:0] wake_word = {ws_en_reg, ws_up_reg,
		ws_down_reg, ws_man_reg, ws_burst_reg, wake_power_up,
		ws_errmet_reg, ws_datmet_reg, ws_errth_reg, ws_datth_reg};

	// read mux, unmapped addresses read zero
	// strobes never overlap, so the priority is harmless
	always_comb begin
		rdata_next = `PTE_DATA_ZERO;
		if (rd_line) begin
			rdata_next = line_word;
		end else if (rd_extra) begin
			rdata_next = extra_word;
		end else if (rd_wake) begin
			rdata_next = wake_word;
		end
	end

	// read data stands one cycle after the strobe only
	// zero outside the slot keeps a shared bus quiet
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata_reg <= `PTE_DATA_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;
endmodule : pte_regs

// File: testbench/pte_regs_props.sv
module pte_regs_props #(
	parameter int unsigned QUIET_CYC = 50
) (
	input wire logic clk_sys, // clock
	input wire logic srst, // reset
	input wire logic [4:0] reg_addr, // address
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_wr, // write
	input wire logic reg_rd, // read
	input wire logic [15:0] reg_rdata, // read data
	input wire logic selftest_run, // test run
	input wire pte_pkg::pte_nibble_s rx_nibble, // nibble
	input wire logic selftest_nonstop_mode, // nonstop
	input wire pte_pkg::pte_patt_s patt_ctrl, // pattern
	input wire logic patt_seq_start, // seq start
	input wire logic patt_seq_done, // seq done
	input wire logic jabber_guard_off, // jabber off
	input wire logic link_is_10m, // 10M link
	input wire logic jabber_active, // jabber on
	input wire logic wake_sense_strap, // strap
	input wire pte_pkg::pte_sense_s line_sense, // events
	input wire logic wake_power_up, // power state
	input wire logic wake_up_start, // up pulse
	input wire logic wake_down_start, // down pulse
	input wire logic device_soft_reset // soft reset
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] since_done;
	logic armed;
	logic gap_q;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// cycles since a sequence ended, with the gap it was loaded with
	always_ff @(posedge clk_sys) begin
		if (srst || device_soft_reset || !patt_ctrl.enable) begin
			armed <= 1'b0;
		end else if (patt_seq_done) begin
			armed <= 1'b1;
		end else if (patt_seq_start) begin
			armed <= 1'b0;
		end
		if (patt_seq_done) begin
			since_done <= 12'h001;
			gap_q <= patt_ctrl.gap_long;
		end else if (since_done != 12'hFFF) begin
			since_done <= since_done + 12'h001;
		end
	end
	// bus, nonstop, pattern, soft reset, jabber and power state checks
	read_slot_a: assert property (
		reg_rdata != 16'h0000 |-> $past(reg_rd))
		else $error("read data outside read slot");
	extra_zero_a: assert property (
		reg_rd && reg_addr == 5'h1C |=> (reg_rdata & 16'hFDFF) == 16'h0000)
		else $error("extra control reads non-zero bits");
	nonstop_gate_a: assert property (
		selftest_nonstop_mode |-> $past(selftest_run))
		else $error("nonstop mode without self-test");
	patt_mirror_a: assert property (
		reg_wr && reg_addr == 5'h1B |=> patt_ctrl.enable == $past(reg_wdata[4])
		&& patt_ctrl.gap_long == $past(reg_wdata[2])
		&& patt_ctrl.sel == $past(reg_wdata[1:0]))
		else $error("pattern controls differ from write");
	start_enabled_a: assert property (
		patt_seq_start |-> patt_ctrl.enable)
		else $error("sequence start while disabled");
	gap_wait_a: assert property (
		patt_seq_start && armed |-> since_done >= (gap_q ? 12'h5DC : 12'h3E8))
		else $error("sequence gap too short");
	soft_pulse_a: assert property (
		reg_wr && reg_addr == 5'h1C && reg_wdata[9]
		|=> device_soft_reset ##1 !device_soft_reset)
		else $error("soft reset pulse missing or long");
	jabber_follow_a: assert property (
		!$past(srst) && !device_soft_reset && !$past(device_soft_reset)
		|-> jabber_active == ($past(link_is_10m) && !$past(jabber_guard_off)))
		else $error("jabber state wrong");
	wake_up_a: assert property (
		wake_up_start |-> !wake_power_up ##1 wake_power_up)
		else $error("power up start wrong");
	sleep_down_a: assert property (
		wake_down_start && !device_soft_reset |-> wake_power_up ##1 !wake_power_up)
		else $error("power down start wrong");
endmodule : pte_regs_props
bind pte_regs pte_regs_props #(.QUIET_CYC(QUIET_CYC)) pte_regs_props_inst (.*);

// File: testbench/phy_test_and_energy_detect_regs_tb_top.sv
module phy_test_and_energy_detect_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QC = 50;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic selftest_run = 1'b0;
	logic patt_seq_done = 1'b0;
	logic jabber_guard_off = 1'b0;
	logic link_is_10m = 1'b0;
	logic wake_sense_strap = 1'b1;
	pte_pkg::pte_nibble_s rx_nibble = 2'b00;
	pte_pkg::pte_sense_s line_sense = 3'b001;
	pte_pkg::pte_patt_s patt_ctrl;
	logic selftest_nonstop_mode, patt_seq_start, jabber_active;
	logic wake_power_up, wake_up_start, wake_down_start, device_soft_reset;
	int fail_count = 0;
	int checked = 0;
	int seed = 73249;
	int tally_m, n, dly = 0, cyc = 0, t_done = 0, gap_seen = 0;
	pte_regs #(.QUIET_CYC(QC)) pte_regs_inst (.*);
	initial forever #5 clk_sys = ~clk_sys;
	// stand-in line driver: ends each sequence a few cycles on
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (patt_seq_start) dly <= 4;
		else if (dly > 0) dly <= dly - 1;
		patt_seq_done <= (dly == 1);
		if (patt_seq_done) t_done <= cyc;
		if (patt_seq_start) gap_seen <= cyc - t_done;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rdc
	// random nibbles, counted by the model as the design samples them
	task automatic feed(input int k);
		for (int j = 0; j <= k; j++) begin
			@(posedge clk_sys);
			if (rx_nibble.valid && rx_nibble.error && tally_m < 255) tally_m++;
			rx_nibble <= (j < k) ? 2'($random(seed)) : 2'b00;
		end
	endtask : feed
	// data events of one cycle, line left at rest between them
	task automatic ev(input int k, input logic [2:0] rest);
		repeat (k) begin
			@(posedge clk_sys);
			line_sense <= 3'b100;
			@(posedge clk_sys);
			line_sense <= rest;
		end
	endtask : ev
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	// tests take about 6k cycles; allow 60k
	initial begin
		#600000;
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		rdc(5'h1B, 16'h0000);
		rdc(5'h1C, 16'h0000);
		rdc(5'h1D, 16'hE411);
		wr(5'h05, 16'hFFFF);
		rdc(5'h05, 16'h0000);
		$display("reset values done");
		// every select code and random gap, reserved bits kept zero
		for (int i = 0; i < 4; i++) begin
			n = $random(seed);
			wr(5'h1B, {n[15:8], 2'b00, n[5], 1'b1, 1'b0, n[2], i[1:0]});
			rdc(5'h1B, {8'h00, 2'b00, n[5], 1'b1, 1'b0, n[2], i[1:0]});
			chk({12'h000, patt_ctrl}, {12'h000, 1'b1, n[2], i[1:0]});
		end
		// spacing between sequences for both gap settings
		for (int g = 1; g >= 0; g--) begin
			wr(5'h1B, g ? 16'h0014 : 16'h0010);
			n = 0;
			for (int k = 0; k < 4000 && n < 2; k++) begin
				@(posedge clk_sys);
				if (patt_seq_start) n++;
			end
			#1 chk(gap_seen[15:0], 16'((g ? 15000 : 10000) / 10 + 1));
		end
		$display("pattern tests done");
		// tally: counts bad nibbles, sticks at top, restart clears
		@(posedge clk_sys);
		link_is_10m <= 1'b1;
		jabber_guard_off <= 1'b1;
		wr(5'h1B, 16'h0020);
		@(posedge clk_sys);
		selftest_run <= 1'b1;
		tally_m = 0;
		feed(40);
		rdc(5'h1B, {tally_m[7:0], 8'h20});
		chk({15'h0000, selftest_nonstop_mode}, 16'h0001);
		feed(1200);
		rdc(5'h1B, {tally_m[7:0], 8'h20});
		@(posedge clk_sys);
		selftest_run <= 1'b0;
		@(posedge clk_sys);
		selftest_run <= 1'b1;
		tally_m = 0;
		feed(40);
		rdc(5'h1B, {tally_m[7:0], 8'h20});
		$display("tally tests done");
		// soft reset keeps settings and reads back zero
		wr(5'h1D, 16'hE0F3);
		wr(5'h1C, 16'hFFFF);
		rdc(5'h1C, 16'h0000);
		rdc(5'h1B, 16'h0020);
		rdc(5'h1D, 16'hE4F3);
		// sleep without energy, wake at threshold, quiet time
		@(posedge clk_sys);
		line_sense <= 3'b000;
		rdc(5'h1D, 16'hE0F3);
		ev(2, 3'b000);
		repeat (QC + 10) @(posedge clk_sys);
		ev(1, 3'b000);
		rdc(5'h1D, 16'hE0F3);
		ev(1, 3'b000);
		ev(1, 3'b001);
		rdc(5'h1D, 16'hE5F3);
		rdc(5'h1D, 16'hE4F3);
		wr(5'h1D, 16'hF0F3);
		rdc(5'h1D, 16'hE0F3);
		wr(5'h1D, 16'hF0F3);
		rdc(5'h1D, 16'hE4F3);
		wr(5'h1D, 16'h60F3);
		rdc(5'h1D, 16'h64F3);
		// one error event against a threshold of one
		wr(5'h1D, 16'hE013);
		@(posedge clk_sys);
		line_sense <= 3'b011;
		@(posedge clk_sys);
		line_sense <= 3'b001;
		rdc(5'h1D, 16'hE613);
		rdc(5'h1D, 16'hE413);
		$display("wake tests done");
		// mid-run reset with the strap low: enable follows it
		@(posedge clk_sys);
		wake_sense_strap <= 1'b0;
		srst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		srst <= 1'b0;
		rdc(5'h1D, 16'h6411);
		rdc(5'h1B, 16'h0000);
		$display("second reset done");
		// jabber in force only on a 10M link without the guard
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			{link_is_10m, jabber_guard_off} <= i[1:0];
			repeat (2) @(posedge clk_sys);
			#1 chk({15'h0000, jabber_active}, {15'h0000, i[1] & ~i[0]});
		end
		$display("jabber tests done");
		wrap_up();
	end
endmodule : phy_test_and_energy_detect_regs_tb_top
